// ===== core/lf_cmd_pkg.sv
// Constants and check helpers shared by both ends of the LF command link
// ------------------------------------------------------------------
// What this block does
// - Repeat command resends last response unchanged
// - Responses: 0xFE header, payload, check byte
// - Read request: id, address, count, check
// - Read answer: status then data, max 16
// - Key and config ranges are never accessible
// - Status: last command id, then code
// - Write request: id, address, data, lock, check
// - Write into locked section aborts with error
// - Station sends 1-4 bytes; transponder takes 128 enhanced
// - Write answer carries only the status
// - Protect byte: two bits per section
// - Section locks can never be cleared
// - Locks guard only three sections, link writes
// - Leave command clears enhanced mode flag
// - Leaving enhanced mode enables power switch
// - Command byte: id plus check nibble
// - Check byte guards data both directions
// - Station resends on downlink check error
// - Station: repeat, resend, then reset device
// - Enhanced mode runs link from battery
// - Status byte kept volatile, refreshed
// ------------------------------------------------------------------
package lf_cmd_pkg;
  localparam logic [3:0] CMD_REPEAT  = 4'hE;
  localparam logic [3:0] CMD_READ    = 4'h4;
  localparam logic [3:0] CMD_WRITE   = 4'h5;
  localparam logic [3:0] CMD_PROTECT = 4'h6;
  localparam logic [3:0] CMD_LEAVE   = 4'hA;
  localparam logic [7:0] HEADER      = 8'hFE;
  localparam logic [7:0] CRC_POLY    = 8'h07;
  localparam logic [7:0] CRC_INIT    = 8'h00;
  localparam logic [3:0] STS_OK        = 4'h0;
  localparam logic [3:0] STS_FRAME_CRC = 4'h1;
  localparam logic [3:0] STS_CMD_CHECK = 4'h2;
  localparam logic [3:0] STS_RANGE     = 4'h3;
  localparam logic [3:0] STS_LOCKED    = 4'h4;
  localparam logic [3:0] STS_LENGTH    = 4'h5;
  localparam logic [3:0] STS_UNKNOWN   = 4'h6;
  localparam logic [15:0] KEY_LO = 16'h0780;
  localparam logic [15:0] KEY_HI = 16'h07FF;
  localparam logic [15:0] CFG_LO = 16'h0817;
  localparam logic [15:0] CFG_HI = 16'h0826;
  localparam int          SECTIONS = 3;
  localparam logic [15:0] SEC_LO [SECTIONS] = '{16'h0000, 16'h0100, 16'h0200};
  localparam logic [15:0] SEC_HI [SECTIONS] = '{16'h00FF, 16'h01FF, 16'h02FF};
  localparam logic [1:0]  LOCK_CODE = 2'h3;
  localparam logic [7:0] READ_MAX         = 8'h10;
  localparam logic [7:0] WRITE_MAX_NORMAL = 8'h04;
  localparam logic [7:0] WRITE_MAX_ENH    = 8'h80;
  localparam logic [7:0] LEN_BARE         = 8'h01;
  localparam logic [7:0] LEN_READ         = 8'h05;
  localparam logic [7:0] LEN_PROTECT      = 8'h03;
  localparam logic [7:0] WRITE_OVERHEAD   = 8'h05;
  localparam logic [7:0] RX_DEPTH         = 8'h85;
  localparam logic [4:0] RESP_FIXED       = 5'h02;
  localparam int         TX_DEPTH         = 18;

  // Nibble table shared by both ends
  function automatic logic [3:0] check_nibble(input logic [3:0] id);
    unique case (id)
      4'h1: return 4'h3;
      4'h3: return 4'h5;
      4'h4: return 4'hC;
      4'h5: return 4'hF;
      4'h6: return 4'hA;
      4'h7: return 4'h9;
      4'h8: return 4'hB;
      4'hA: return 4'hD;
      4'hE: return 4'h1;
      default: return ~id;
    endcase
  endfunction

  // Appending the result to the bytes makes the running value zero
  function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++)
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    return c;
  endfunction
endpackage

// ===== core/lf_link_if.sv
// Byte-level downlink and uplink between station and transponder
`timescale 1ns/1ns
interface lf_link_if;
  logic       dn_valid;
  logic       dn_last;
  logic [7:0] dn_data;
  logic       up_valid;
  logic       up_last;
  logic [7:0] up_data;
  modport transponder (input dn_valid, dn_last, dn_data, output up_valid, up_last, up_data);
  modport station (output dn_valid, dn_last, dn_data, input up_valid, up_last, up_data);
endinterface

// ===== core/lf_station_cmd.sv
// Base station end: frames commands, checks answers, runs the retry ladder
`timescale 1ns/1ns
module lf_station_cmd (
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  lf_link_if.station        link,
  input  wire logic         go_i,
  input  wire logic [3:0]   cmd_i,
  input  wire logic [15:0]  addr_i,
  input  wire logic [7:0]   len_i,
  input  wire logic [31:0]  wdata_i,
  input  wire logic [7:0]   arg_i,
  output logic              busy_o,
  output logic              done_o,
  output logic              fail_o,
  output logic              reset_device_o,
  output logic [7:0]        status_o,
  output logic [127:0]      rdata_o
);
  typedef enum logic [1:0] {
    S_IDLE  = 2'h0,
    S_SEND  = 2'h1,
    S_WAIT  = 2'h2,
    S_CHECK = 2'h3
  } state_t;

  state_t     state;
  logic [7:0] fbuf [8];
  logic [3:0] flen;
  logic [3:0] cur_len;
  logic [3:0] sidx;
  logic [7:0] scrc;
  logic [7:0] sbyte;
  logic       rep;
  logic [1:0] tries;
  logic [7:0] rbuf [lf_cmd_pkg::TX_DEPTH];
  logic [4:0] ridx;
  logic [7:0] rcrc;
  logic [2:0] wn;
  logic       up_ok;

  always_comb
  begin
    cur_len = rep ? 4'h1 : flen;
    sbyte   = rep ? {lf_cmd_pkg::CMD_REPEAT, lf_cmd_pkg::check_nibble(lf_cmd_pkg::CMD_REPEAT)}
                  : fbuf[sidx[2:0]];
    wn      = (len_i == 8'h00) ? 3'h1 : (len_i > 8'h04) ? 3'h4 : len_i[2:0];
    up_ok   = rcrc == 8'h00 && rbuf[0] == lf_cmd_pkg::HEADER
           && ridx > lf_cmd_pkg::RESP_FIXED;
  end

  // ------------------------------------------------------------
  // Request framing
  // ------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      flen <= 4'h1;
    else if (state == S_IDLE && go_i)
    begin
      fbuf[0] <= {cmd_i, lf_cmd_pkg::check_nibble(cmd_i)};
      fbuf[1] <= addr_i[15:8];
      fbuf[2] <= addr_i[7:0];
      unique case (cmd_i)
        lf_cmd_pkg::CMD_READ:
        begin
          fbuf[3] <= len_i;
          flen    <= 4'h4;
        end
        lf_cmd_pkg::CMD_WRITE:
        begin
          for (int k = 0; k < 4; k++)
            fbuf[3 + k] <= wdata_i[8*k +: 8];
          fbuf[3'h3 + wn] <= arg_i;
          flen <= 4'h4 + {1'b0, wn};
        end
        lf_cmd_pkg::CMD_PROTECT:
        begin
          fbuf[1] <= arg_i;
          flen    <= 4'h2;
        end
        default:
          flen <= 4'h1;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Link traffic and retries
  // ------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      state          <= S_IDLE;
      rep            <= 1'b0;
      tries          <= 2'h0;
      sidx           <= 4'h0;
      scrc           <= lf_cmd_pkg::CRC_INIT;
      ridx           <= 5'h00;
      rcrc           <= lf_cmd_pkg::CRC_INIT;
      busy_o         <= 1'b0;
      done_o         <= 1'b0;
      fail_o         <= 1'b0;
      reset_device_o <= 1'b0;
      status_o       <= 8'h00;
      rdata_o        <= 128'h0;
      link.dn_valid  <= 1'b0;
      link.dn_last   <= 1'b0;
      link.dn_data   <= 8'h00;
    end
    else
    begin
      done_o         <= 1'b0;
      fail_o         <= 1'b0;
      reset_device_o <= 1'b0;
      link.dn_valid  <= 1'b0;
      link.dn_last   <= 1'b0;
      unique case (state)
        S_IDLE:
          if (go_i)
          begin
            state  <= S_SEND;
            busy_o <= 1'b1;
            rep    <= 1'b0;
            tries  <= 2'h0;
            sidx   <= 4'h0;
            scrc   <= lf_cmd_pkg::CRC_INIT;
          end
        S_SEND:
        begin
          link.dn_valid <= 1'b1;
          sidx          <= sidx + 4'h1;
          if (sidx < cur_len)
          begin
            link.dn_data <= sbyte;
            scrc         <= lf_cmd_pkg::crc8(scrc, sbyte);
            link.dn_last <= cur_len == 4'h1;
          end
          else
          begin
            link.dn_data <= scrc;
            link.dn_last <= 1'b1;
          end
          if ((cur_len == 4'h1) || (sidx == cur_len))
          begin
            state <= S_WAIT;
            ridx  <= 5'h00;
            rcrc  <= lf_cmd_pkg::CRC_INIT;
          end
        end
        S_WAIT:
          if (link.up_valid)
          begin
            if (ridx < 5'(lf_cmd_pkg::TX_DEPTH))
            begin
              rbuf[ridx] <= link.up_data;
              ridx       <= ridx + 5'h01;
            end
            rcrc <= lf_cmd_pkg::crc8(rcrc, link.up_data);
            if (link.up_last)
              state <= S_CHECK;
          end
        S_CHECK:
        begin
          sidx  <= 4'h0;
          scrc  <= lf_cmd_pkg::CRC_INIT;
          state <= S_SEND;
          tries <= tries + 2'h1;
          if (up_ok && rbuf[1][3:0] != lf_cmd_pkg::STS_FRAME_CRC
              && rbuf[1][3:0] != lf_cmd_pkg::STS_CMD_CHECK)
          begin
            state    <= S_IDLE;
            busy_o   <= 1'b0;
            done_o   <= 1'b1;
            status_o <= rbuf[1];
            for (int k = 0; k < 16; k++)
              rdata_o[8*k +: 8] <= rbuf[k + 2];
          end
          else if (tries == 2'h2)
          begin
            state          <= S_IDLE;
            busy_o         <= 1'b0;
            fail_o         <= 1'b1;
            reset_device_o <= 1'b1;
            if (up_ok)
              status_o <= rbuf[1];
          end
          else
            rep <= !up_ok && tries == 2'h0;
        end
      endcase
    end
  end
endmodule

// ===== core/lf_transponder_cmd.sv
// Transponder command interpreter for memory, protection and mode commands
//
// Design decisions made here: single-cycle strobed memory reads and writes.
`timescale 1ns/1ns
module lf_transponder_cmd (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  lf_link_if.transponder   link,
  output logic [15:0]      mem_addr_o,
  output logic [7:0]       mem_wdata_o,
  output logic             mem_we_o,
  output logic             mem_re_o,
  input  wire logic [7:0]  mem_rdata_i,
  input  wire logic        enhanced_i,
  input  wire logic [2:0]  lock_saved_i,
  output logic [2:0]       lock_o,
  output logic             enh_clear_o,
  output logic             power_switch_en_o,
  output logic             battery_supply_o,
  output logic [7:0]       status_o
);
  typedef enum logic [2:0] {
    ST_RX    = 3'h0,
    ST_EXEC  = 3'h1,
    ST_RDMEM = 3'h2,
    ST_WRMEM = 3'h3,
    ST_TX    = 3'h4
  } state_t;

  state_t      state;
  logic [7:0]  rx_buf [lf_cmd_pkg::RX_DEPTH];
  logic [7:0]  rx_cnt;
  logic [7:0]  rx_crc;
  logic [7:0]  tx_buf [lf_cmd_pkg::TX_DEPTH];
  logic [4:0]  tx_len;
  logic [4:0]  tx_idx;
  logic [7:0]  tx_crc;
  logic [15:0] op_addr;
  logic [7:0]  op_left;
  logic [7:0]  op_idx;
  logic        rd_pend;
  logic        lock_loaded;
  logic        leaving;

  logic [3:0]  cmd_id;
  logic        nib_ok;
  logic        crc_ok;
  logic [15:0] addr;
  logic [7:0]  nbytes;
  logic [15:0] last_addr;
  logic        forbidden;
  logic        locked;
  logic [3:0]  code;

  // ------------------------------------------------------------
  // Request capture
  // ------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      rx_cnt <= 8'h00;
      rx_crc <= lf_cmd_pkg::CRC_INIT;
    end
    else if (state == ST_RX && link.dn_valid)
    begin
      if (rx_cnt < lf_cmd_pkg::RX_DEPTH)
        rx_buf[rx_cnt] <= link.dn_data;
      if (rx_cnt != 8'hFF)
        rx_cnt <= rx_cnt + 8'h01;
      rx_crc <= lf_cmd_pkg::crc8(rx_crc, link.dn_data);
    end
    else if (state == ST_EXEC)
    begin
      rx_cnt <= 8'h00;
      rx_crc <= lf_cmd_pkg::CRC_INIT;
    end
  end

  // ------------------------------------------------------------
  // Request decode
  // ------------------------------------------------------------
  always_comb
  begin
    cmd_id    = rx_buf[0][7:4];
    nib_ok    = rx_buf[0][3:0] == lf_cmd_pkg::check_nibble(cmd_id);
    crc_ok    = rx_crc == 8'h00;
    addr      = {rx_buf[1], rx_buf[2]};
    nbytes    = (cmd_id == lf_cmd_pkg::CMD_READ) ? rx_buf[3]
                                                 : rx_cnt - lf_cmd_pkg::WRITE_OVERHEAD;
    last_addr = addr + {8'h00, nbytes} - 16'h0001;
    forbidden = (addr <= lf_cmd_pkg::KEY_HI && last_addr >= lf_cmd_pkg::KEY_LO)
             || (addr <= lf_cmd_pkg::CFG_HI && last_addr >= lf_cmd_pkg::CFG_LO);
    locked    = 1'b0;
    for (int s = 0; s < lf_cmd_pkg::SECTIONS; s++)
      if (lock_o[s] && addr <= lf_cmd_pkg::SEC_HI[s] && last_addr >= lf_cmd_pkg::SEC_LO[s])
        locked = 1'b1;
    code = lf_cmd_pkg::STS_OK;
    if (!nib_ok)
      code = lf_cmd_pkg::STS_CMD_CHECK;
    else
    begin
      unique case (cmd_id)
        lf_cmd_pkg::CMD_REPEAT, lf_cmd_pkg::CMD_LEAVE:
          if (rx_cnt != lf_cmd_pkg::LEN_BARE)
            code = lf_cmd_pkg::STS_LENGTH;
        lf_cmd_pkg::CMD_READ:
          if (rx_cnt != lf_cmd_pkg::LEN_READ)
            code = lf_cmd_pkg::STS_LENGTH;
          else if (!crc_ok)
            code = lf_cmd_pkg::STS_FRAME_CRC;
          else if (nbytes == 8'h00 || nbytes > lf_cmd_pkg::READ_MAX)
            code = lf_cmd_pkg::STS_LENGTH;
          else if (forbidden)
            code = lf_cmd_pkg::STS_RANGE;
        lf_cmd_pkg::CMD_WRITE:
          if (rx_cnt <= lf_cmd_pkg::WRITE_OVERHEAD || rx_cnt > lf_cmd_pkg::RX_DEPTH)
            code = lf_cmd_pkg::STS_LENGTH;
          else if (!crc_ok)
            code = lf_cmd_pkg::STS_FRAME_CRC;
          else if (nbytes > (enhanced_i ? lf_cmd_pkg::WRITE_MAX_ENH
                                        : lf_cmd_pkg::WRITE_MAX_NORMAL))
            code = lf_cmd_pkg::STS_LENGTH;
          else if (forbidden)
            code = lf_cmd_pkg::STS_RANGE;
          else if (locked)
            code = lf_cmd_pkg::STS_LOCKED;
        lf_cmd_pkg::CMD_PROTECT:
          if (rx_cnt != lf_cmd_pkg::LEN_PROTECT)
            code = lf_cmd_pkg::STS_LENGTH;
          else if (!crc_ok)
            code = lf_cmd_pkg::STS_FRAME_CRC;
        default:
          code = lf_cmd_pkg::STS_UNKNOWN;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Command sequencing and memory access
  // ------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      state       <= ST_RX;
      status_o    <= 8'h00;
      tx_len      <= 5'h00;
      op_addr     <= 16'h0000;
      op_left     <= 8'h00;
      op_idx      <= 8'h00;
      rd_pend     <= 1'b0;
      mem_addr_o  <= 16'h0000;
      mem_wdata_o <= 8'h00;
      mem_we_o    <= 1'b0;
      mem_re_o    <= 1'b0;
      enh_clear_o <= 1'b0;
    end
    else
    begin
      mem_we_o    <= 1'b0;
      mem_re_o    <= 1'b0;
      enh_clear_o <= 1'b0;
      unique case (state)
        ST_RX:
          if (link.dn_valid && link.dn_last)
            state <= ST_EXEC;
        ST_EXEC:
        begin
          state <= ST_TX;
          // Empty history answers with a fresh status frame instead
          if (!(cmd_id == lf_cmd_pkg::CMD_REPEAT && code == lf_cmd_pkg::STS_OK
                && tx_len != 5'h00))
          begin
            status_o  <= {cmd_id, code};
            tx_buf[0] <= lf_cmd_pkg::HEADER;
            tx_buf[1] <= {cmd_id, code};
            tx_len    <= lf_cmd_pkg::RESP_FIXED;
            op_addr   <= addr;
            op_left   <= nbytes;
            op_idx    <= 8'h00;
            if (code == lf_cmd_pkg::STS_OK && cmd_id == lf_cmd_pkg::CMD_READ)
              state <= ST_RDMEM;
            if (code == lf_cmd_pkg::STS_OK && cmd_id == lf_cmd_pkg::CMD_WRITE)
              state <= ST_WRMEM;
            if (code == lf_cmd_pkg::STS_OK && cmd_id == lf_cmd_pkg::CMD_LEAVE)
              enh_clear_o <= 1'b1;
          end
        end
        ST_RDMEM:
        begin
          if (op_left != 8'h00)
          begin
            mem_re_o   <= 1'b1;
            mem_addr_o <= op_addr;
            op_addr    <= op_addr + 16'h0001;
            op_left    <= op_left - 8'h01;
          end
          rd_pend <= mem_re_o;
          if (rd_pend)
          begin
            tx_buf[tx_len] <= mem_rdata_i;
            tx_len         <= tx_len + 5'h01;
          end
          if (op_left == 8'h00 && !mem_re_o && !rd_pend)
            state <= ST_TX;
        end
        ST_WRMEM:
          if (op_left != 8'h00)
          begin
            mem_we_o    <= 1'b1;
            mem_addr_o  <= op_addr;
            mem_wdata_o <= rx_buf[8'h03 + op_idx];
            op_addr     <= op_addr + 16'h0001;
            op_idx      <= op_idx + 8'h01;
            op_left     <= op_left - 8'h01;
          end
          else
            state <= ST_TX;
        ST_TX:
          if (tx_idx == tx_len + 5'h01)
            state <= ST_RX;
        default:
          state <= ST_RX;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Section locks and supply mode
  // ------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      lock_o      <= 3'h0;
      lock_loaded <= 1'b0;
    end
    else if (!lock_loaded)
    begin
      // Saved lock state is taken in the first cycle after reset
      lock_o      <= lock_saved_i;
      lock_loaded <= 1'b1;
    end
    else if (state == ST_EXEC && cmd_id == lf_cmd_pkg::CMD_PROTECT
             && code == lf_cmd_pkg::STS_OK)
    begin
      for (int s = 0; s < lf_cmd_pkg::SECTIONS; s++)
        if (rx_buf[1][2*s +: 2] == lf_cmd_pkg::LOCK_CODE)
          lock_o[s] <= 1'b1;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      leaving           <= 1'b0;
      power_switch_en_o <= 1'b0;
      battery_supply_o  <= 1'b0;
    end
    else
    begin
      if (enh_clear_o)
        leaving <= 1'b1;
      // Switch stays on until the field supply forces a power-on reset
      power_switch_en_o <= !enhanced_i || leaving;
      battery_supply_o  <= enhanced_i && !leaving;
    end
  end

  // ------------------------------------------------------------
  // Response transmit
  // ------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (rst_i || state != ST_TX)
    begin
      tx_idx        <= 5'h00;
      tx_crc        <= lf_cmd_pkg::CRC_INIT;
      link.up_valid <= 1'b0;
      link.up_last  <= 1'b0;
      link.up_data  <= 8'h00;
    end
    else if (tx_idx < tx_len)
    begin
      link.up_valid <= 1'b1;
      link.up_last  <= 1'b0;
      link.up_data  <= tx_buf[tx_idx];
      tx_crc        <= lf_cmd_pkg::crc8(tx_crc, tx_buf[tx_idx]);
      tx_idx        <= tx_idx + 5'h01;
    end
    else if (tx_idx == tx_len)
    begin
      link.up_valid <= 1'b1;
      link.up_last  <= 1'b1;
      link.up_data  <= tx_crc;
      tx_idx        <= tx_idx + 5'h01;
    end
    else
    begin
      link.up_valid <= 1'b0;
      link.up_last  <= 1'b0;
    end
  end
endmodule

// ===== sim/lf_link_properties.sv
// Concurrent checks on the byte link between station and transponder
`timescale 1ns/1ns
module lf_link_properties (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       dn_valid,
  input  wire logic       dn_last,
  input  wire logic [7:0] dn_data,
  input  wire logic       up_valid,
  input  wire logic       up_last,
  input  wire logic [7:0] up_data
);
  logic [7:0] up_crc;
  logic [7:0] dn_crc;
  logic       up_mid;
  logic       dn_mid;
  logic       wait_ans;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  // Own check step, kept apart from the design's helper on purpose
  function automatic logic [7:0] step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
      r = {r[6:0], 1'b0} ^ (r[7] ? 8'h07 : 8'h00);
    return r;
  endfunction

  // ------------------------------------------------------------------
  // Frame tracking
  // ------------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    up_crc <= (rst_i || up_last) ? 8'h00 : (up_valid ? step(up_crc, up_data) : up_crc);
    up_mid <= !rst_i && (up_valid ? !up_last : up_mid);
  end

  always_ff @(posedge clock_i)
  begin
    dn_crc <= (rst_i || dn_last) ? 8'h00 : (dn_valid ? step(dn_crc, dn_data) : dn_crc);
    dn_mid <= !rst_i && (dn_valid ? !dn_last : dn_mid);
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i || (up_valid && up_last))
      wait_ans <= 1'b0;
    else if (dn_valid && dn_last)
      wait_ans <= 1'b1;
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  resp_header_a: assert property (up_valid && !up_mid |-> up_data == 8'hFE)
    else $error("answer does not open with the header byte");
  up_check_a: assert property (up_valid && up_last |-> step(up_crc, up_data) == 8'h00)
    else $error("uplink check byte wrong");
  dn_check_a: assert property (dn_valid && dn_last && dn_mid |-> step(dn_crc, dn_data) == 8'h00)
    else $error("downlink check byte wrong");
  cmd_nibble_a: assert property (dn_valid && !dn_mid |->
    (dn_data[7:4] != 4'h4 || dn_data[3:0] == 4'hC) && (dn_data[7:4] != 4'h5 || dn_data[3:0] == 4'hF)
    && (dn_data[7:4] != 4'h6 || dn_data[3:0] == 4'hA) && (dn_data[7:4] != 4'hA || dn_data[3:0] == 4'hD)
    && (dn_data[7:4] != 4'hE || dn_data[3:0] == 4'h1)) else $error("command nibble wrong");
  answer_gap_a: assert property (dn_valid && dn_last |=> !up_valid [*2])
    else $error("answer starts too early");
  answer_bound_a: assert property (dn_valid && dn_last |-> ##[3:40] up_valid)
    else $error("no answer to a request");
  up_burst_a: assert property (up_valid && !up_last |=> up_valid)
    else $error("answer bytes not back to back");
  up_last_valid_a: assert property (up_last |-> up_valid)
    else $error("last marker without a byte");
  dn_order_a: assert property (wait_ans |-> !dn_valid)
    else $error("request sent before the answer ended");

  cover property (dn_valid && !dn_mid && dn_data == 8'h4C);
  cover property (dn_valid && !dn_mid && dn_data == 8'h5F);
  cover property (dn_valid && !dn_mid && dn_data == 8'hE1);
endmodule

// ===== sim/lf_transponder_memory_commands_tb_top.sv
// Testbench joining station and transponder ends over the byte link
`timescale 1ns/1ns
module lf_transponder_memory_commands_tb_top;
  logic         clock_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         go_i = 1'b0;
  logic [3:0]   cmd_i = 4'h0;
  logic [15:0]  addr_i = 16'h0000;
  logic [7:0]   len_i = 8'h00;
  logic [31:0]  wdata_i = 32'h0000_0000;
  logic [7:0]   arg_i = 8'h00;
  logic [7:0]   mem_rdata = 8'h00;
  logic         enhanced = 1'b1;
  logic [2:0]   lock_saved = 3'h2;
  logic         done, fail, busy, mem_we, mem_re, enh_clear, pwr_en, batt;
  logic [2:0]   lock;
  logic [7:0]   st_status, dev_status, mem_wdata;
  logic [15:0]  mem_addr;
  logic [127:0] rdata;
  logic [7:0]   mem [0:4095];
  logic [3:0]   last_id;
  int           enh_count = 0;
  int           fail_count = 0;
  int           compares = 0;

  always #50 clock_i = ~clock_i;

  lf_link_if link ();
  lf_station_cmd i_lf_station_cmd (.clock_i(clock_i), .rst_i(rst_i), .link(link),
    .go_i(go_i), .cmd_i(cmd_i), .addr_i(addr_i), .len_i(len_i), .wdata_i(wdata_i),
    .arg_i(arg_i), .busy_o(busy), .done_o(done), .fail_o(fail), .reset_device_o(),
    .status_o(st_status), .rdata_o(rdata));
  lf_transponder_cmd i_lf_transponder_cmd (.clock_i(clock_i), .rst_i(rst_i), .link(link),
    .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_we_o(mem_we), .mem_re_o(mem_re),
    .mem_rdata_i(mem_rdata), .enhanced_i(enhanced), .lock_saved_i(lock_saved),
    .lock_o(lock), .enh_clear_o(enh_clear), .power_switch_en_o(pwr_en),
    .battery_supply_o(batt), .status_o(dev_status));
  lf_link_properties i_lf_link_properties (.clock_i(clock_i), .rst_i(rst_i),
    .dn_valid(link.dn_valid), .dn_last(link.dn_last), .dn_data(link.dn_data),
    .up_valid(link.up_valid), .up_last(link.up_last), .up_data(link.up_data));

  // ------------------------------------------------------------------
  // Memory beside the transponder
  // ------------------------------------------------------------------
  // Idle read data toggles so a late capture cannot match by luck
  always @(posedge clock_i)
  begin
    if (mem_we)
      mem[mem_addr[11:0]] <= mem_wdata;
    mem_rdata <= mem_re ? mem[mem_addr[11:0]] : ~mem_rdata;
    if (enh_clear)
      enh_count <= enh_count + 1;
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic end_sim;
    if (fail_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic run(input logic [3:0] c, input logic [15:0] a, input logic [7:0] n,
                     input logic [31:0] w, input logic [7:0] g, input logic [3:0] code);
    int k = 0;
    logic [3:0] id;
    id = (c == lf_cmd_pkg::CMD_REPEAT) ? last_id : c;
    last_id = id;
    @(posedge clock_i);
    cmd_i <= c;
    addr_i <= a;
    len_i <= n;
    wdata_i <= w;
    arg_i <= g;
    go_i <= 1'b1;
    @(posedge clock_i);
    go_i <= 1'b0;
    do
    begin
      @(posedge clock_i);
      #1;
      k++;
    end
    while (done !== 1'b1 && fail !== 1'b1 && k < 400);
    chk("done", 32'h1, 32'(done));
    chk("busy", 32'h0, 32'(busy));
    chk("status", {24'h0, id, code}, 32'(st_status));
    chk("dev_status", {24'h0, id, code}, 32'(dev_status));
  endtask

  task automatic rd_chk(input logic [15:0] a, input int n);
    for (int k = 0; k < n; k++)
      chk("rdata", 32'(mem[a[11:0] + 12'(k)]), 32'(rdata[8*k +: 8]));
  endtask

  task automatic t_read_range;
    run(lf_cmd_pkg::CMD_READ, 16'h0300, 8'h10, 32'h0, 8'h00, lf_cmd_pkg::STS_OK);
    rd_chk(16'h0300, 16);
    run(lf_cmd_pkg::CMD_READ, 16'h0300, 8'h11, 32'h0, 8'h00, lf_cmd_pkg::STS_LENGTH);
    run(lf_cmd_pkg::CMD_READ, 16'h077F, 8'h01, 32'h0, 8'h00, lf_cmd_pkg::STS_OK);
    run(lf_cmd_pkg::CMD_READ, 16'h077F, 8'h02, 32'h0, 8'h00, lf_cmd_pkg::STS_RANGE);
    run(lf_cmd_pkg::CMD_READ, 16'h0810, 8'h08, 32'h0, 8'h00, lf_cmd_pkg::STS_RANGE);
    run(lf_cmd_pkg::CMD_READ, 16'h0827, 8'h01, 32'h0, 8'h00, lf_cmd_pkg::STS_OK);
  endtask

  task automatic t_repeat;
    run(lf_cmd_pkg::CMD_READ, 16'h0040, 8'h03, 32'h0, 8'h00, lf_cmd_pkg::STS_OK);
    run(lf_cmd_pkg::CMD_REPEAT, 16'h0, 8'h00, 32'h0, 8'h00, lf_cmd_pkg::STS_OK);
    rd_chk(16'h0040, 3);
    run(4'h9, 16'h0, 8'h00, 32'h0, 8'h00, lf_cmd_pkg::STS_UNKNOWN);
    run(lf_cmd_pkg::CMD_REPEAT, 16'h0, 8'h00, 32'h0, 8'h00, lf_cmd_pkg::STS_UNKNOWN);
  endtask

  task automatic t_write_lock;
    chk("lock", 32'h2, 32'(lock));
    run(lf_cmd_pkg::CMD_WRITE, 16'h0300, 8'h04, 32'hA1B2C3D4, 8'h00, lf_cmd_pkg::STS_OK);
    chk("mem", 32'hA1B2C3D4, {mem[12'h303], mem[12'h302], mem[12'h301], mem[12'h300]});
    run(lf_cmd_pkg::CMD_WRITE, 16'h0150, 8'h01, 32'h77, 8'h00, lf_cmd_pkg::STS_LOCKED);
    chk("kept", 32'h0A, 32'(mem[12'h150]));
    run(lf_cmd_pkg::CMD_PROTECT, 16'h0, 8'h00, 32'h0, 8'h03, lf_cmd_pkg::STS_OK);
    chk("lock", 32'h3, 32'(lock));
    run(lf_cmd_pkg::CMD_WRITE, 16'h0010, 8'h01, 32'h77, 8'h00, lf_cmd_pkg::STS_LOCKED);
    run(lf_cmd_pkg::CMD_PROTECT, 16'h0, 8'h00, 32'h0, 8'h00, lf_cmd_pkg::STS_OK);
    chk("lock", 32'h3, 32'(lock));
    run(lf_cmd_pkg::CMD_PROTECT, 16'h0, 8'h00, 32'h0, 8'h33, lf_cmd_pkg::STS_OK);
    chk("lock", 32'h7, 32'(lock));
    run(lf_cmd_pkg::CMD_WRITE, 16'h0300, 8'h01, 32'h55, 8'h00, lf_cmd_pkg::STS_OK);
    chk("mem", 32'h55, 32'(mem[12'h300]));
  endtask

  task automatic t_leave;
    chk("battery", 32'h1, 32'(batt));
    run(lf_cmd_pkg::CMD_LEAVE, 16'h0, 8'h00, 32'h0, 8'h00, lf_cmd_pkg::STS_OK);
    chk("clear_pulses", 32'h1, 32'(enh_count));
    chk("power_switch", 32'h1, 32'(pwr_en));
    chk("battery", 32'h0, 32'(batt));
  endtask

  // ------------------------------------------------------------------
  // Sequence and watchdog
  // ------------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 4096; i++)
      mem[i] = 8'(i) ^ 8'h5A;
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    t_read_range();
    t_repeat();
    t_write_lock();
    t_leave();
    end_sim();
  end

  // About 350 cycles expected; ten thousand is ample
  initial
  begin
    #1_000_000;
    fail_count++;
    end_sim();
  end
endmodule
